/* src/peb_host.sv */
// Host controller driving a byte-wide self-timed nonvolatile memory
// Operation
// - Strobe codes select read, write, standby
// - Wait full write time unless polling
// - Keep page address bits across byte loads; a load with other page bits still goes out and sets page_err
// - Each byte load is single write cycle
// - Output enable pulse between loads polls
// - Polling is an ordinary read cycle
// - Issue page loads without interruption; a plain read between loads still runs and sets page_err
module peb_host
  import peb_pkg::*;
#(
  parameter int WRITE_WAIT = WRITE_WAIT_CYC
) (
  // Clock, reset, enable
  input  wire logic                       core_clk,
  input  wire logic                       srst,
  input  wire logic                       clk_en,
  // User request
  input  wire logic                       req_valid,
  input  wire logic [1:0]                 req_cmd,
  input  wire logic [peb_pkg::ADDR_W-1:0] req_addr,
  input  wire logic [peb_pkg::DATA_W-1:0] req_wdata,
  input  wire logic                       req_last,
  output logic                            req_ready,
  // User answer
  output logic                            rsp_valid,
  output logic [peb_pkg::DATA_W-1:0]      rsp_rdata,
  output logic                            page_err,
  output logic                            write_busy,
  // Memory pins
  output logic [peb_pkg::ADDR_W-1:0]      mem_addr,
  output logic                            mem_cs_n,
  output logic                            mem_oe_n,
  output logic                            mem_we_n,
  input  wire logic [peb_pkg::DATA_W-1:0] mem_dq_i,
  output logic [peb_pkg::DATA_W-1:0]      mem_dq_o,
  output logic                            mem_dq_oe
);

  import peb_pkg::*;

  // ----------------------------------------------------------------
  // Pin input synchroniser
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] dq_s1_q, dq_s2_q;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      dq_s1_q <= '0;
      dq_s2_q <= '0;
    end else if (clk_en) begin
      dq_s1_q <= mem_dq_i;
      dq_s2_q <= dq_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  peb_state_t        st_q, st_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [DATA_W-1:0] wdat_q, wdat_d, rdat_q, rdat_d;
  logic              cs_q, cs_d, oe_q, oe_d, we_q, we_d, dqoe_q, dqoe_d;
  logic              rdy_q, rdy_d, rv_q, rv_d, perr_q, perr_d, busy_q, busy_d;
  logic              last_q, last_d, inpage_q, inpage_d;
  logic              csn_q, csn_d, oen_q, oen_d, wen_q, wen_d;
  logic [ADDR_W-PAGE_OFS_W-1:0] page_q, page_d;
  logic              tload;
  logic [CNT_W-1:0]  tval;
  logic              tdone;

  peb_timer u_timer (
    .core_clk (core_clk),
    .srst     (srst),
    .ce       (clk_en),
    .load     (tload),
    .load_val (tval),
    .done     (tdone)
  );

  // Next-state logic; strobes held active low as pin levels, stored as asserted
  always_comb begin
    st_d     = st_q;
    addr_d   = addr_q;
    wdat_d   = wdat_q;
    rdat_d   = rdat_q;
    cs_d     = cs_q;
    oe_d     = oe_q;
    we_d     = we_q;
    dqoe_d   = dqoe_q;
    rdy_d    = 1'b0;
    rv_d     = 1'b0;
    perr_d   = perr_q;
    busy_d   = busy_q;
    last_d   = last_q;
    inpage_d = inpage_q;
    page_d   = page_q;
    tload    = 1'b0;
    tval     = '0;
    case (st_q)
      PEB_IDLE, PEB_LOADGP: begin
        // Between page loads any request is taken; a plain read also sets page_err
        if (st_q == PEB_LOADGP && tdone) begin
          // Load window expired: the device starts its internal write
          st_d     = PEB_BUSY;
          inpage_d = 1'b0;
          busy_d   = 1'b1;
          tload    = 1'b1;
          tval     = CNT_W'(WRITE_WAIT);
        end else if (req_valid && rdy_q) begin
          addr_d = req_addr;
          wdat_d = req_wdata;
          last_d = req_last;
          tload  = 1'b1;
          if (req_cmd == CMD_WRITE) begin
            // Later loads must share the page of the first one
            if (inpage_q && req_addr[ADDR_W-1:PAGE_OFS_W] != page_q) begin
              perr_d = 1'b1;
            end
            page_d = req_addr[ADDR_W-1:PAGE_OFS_W];
            cs_d   = 1'b1;
            we_d   = 1'b1;
            dqoe_d = 1'b1;
            tval   = CNT_W'(STROBE_CYC);
            st_d   = PEB_WR;
          end else begin
            // Read and poll use the same read cycle
            cs_d = 1'b1;
            oe_d = 1'b1;
            tval = CNT_W'(ACCESS_CYC);
            st_d = PEB_RD;
          end
        end else begin
          rdy_d = 1'b1;
        end
      end
      PEB_RD: begin
        if (tdone) begin
          rdat_d = dq_s2_q;
          rv_d   = 1'b1;
          cs_d   = 1'b0;
          oe_d   = 1'b0;
          tload  = 1'b1;
          tval   = CNT_W'(FLOAT_CYC + 2);
          st_d   = PEB_FLOAT;
        end
      end
      PEB_FLOAT: begin
        // Bus left idle until the memory stops driving
        if (tdone) begin
          st_d  = inpage_q ? PEB_LOADGP : (busy_q ? PEB_BUSY : PEB_IDLE);
          rdy_d = !busy_q || inpage_q;
          if (inpage_q) begin
            tload = 1'b1;
            tval  = CNT_W'(BYTE_LOAD_MAX_CYC);
          end
        end
      end
      PEB_WR: begin
        if (tdone) begin
          we_d  = 1'b0;
          cs_d  = 1'b0;
          tload = 1'b1;
          tval  = CNT_W'(STROBE_CYC);
          st_d  = PEB_RECOV;
        end
      end
      PEB_RECOV: begin
        if (tdone) begin
          dqoe_d = 1'b0;
          tload  = 1'b1;
          if (last_q) begin
            inpage_d = 1'b0;
            busy_d   = 1'b1;
            tval     = CNT_W'(WRITE_WAIT);
            st_d     = PEB_BUSY;
          end else begin
            // Next load must arrive within the byte load window
            inpage_d = 1'b1;
            tval     = CNT_W'(BYTE_LOAD_MAX_CYC);
            rdy_d    = 1'b1;
            st_d     = PEB_LOADGP;
          end
        end
      end
      PEB_BUSY: begin
        // Only polls are taken in BUSY; the first poll clears write_busy and the host then returns to idle
        if (tdone) begin
          busy_d = 1'b0;
          rdy_d  = 1'b1;
          st_d   = PEB_IDLE;
        end else if (req_valid && req_cmd == CMD_POLL) begin
          cs_d   = 1'b1;
          oe_d   = 1'b1;
          busy_d = 1'b0;  // Early completion is judged by software from the data
          tload  = 1'b1;
          tval   = CNT_W'(ACCESS_CYC);
          st_d   = PEB_RD;
        end
      end
      default: begin
        st_d = PEB_IDLE;
      end
    endcase
    if (req_valid && rdy_q && req_cmd == CMD_READ && st_q == PEB_LOADGP) begin
      perr_d = 1'b1;  // Plain read would break a page load; flagged only
    end
    // Pin levels kept in their own flops so the strobes leave without a gate
    csn_d = !cs_d;
    oen_d = !oe_d;
    wen_d = !we_d;
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_q     <= PEB_IDLE;
      addr_q   <= '0;
      wdat_q   <= '0;
      rdat_q   <= '0;
      cs_q     <= 1'b0;
      oe_q     <= 1'b0;
      we_q     <= 1'b0;
      dqoe_q   <= 1'b0;
      rdy_q    <= 1'b0;
      rv_q     <= 1'b0;
      perr_q   <= 1'b0;
      busy_q   <= 1'b0;
      last_q   <= 1'b0;
      inpage_q <= 1'b0;
      page_q   <= '0;
      csn_q    <= 1'b1;
      oen_q    <= 1'b1;
      wen_q    <= 1'b1;
    end else if (clk_en) begin
      st_q     <= st_d;
      addr_q   <= addr_d;
      wdat_q   <= wdat_d;
      rdat_q   <= rdat_d;
      cs_q     <= cs_d;
      oe_q     <= oe_d;
      we_q     <= we_d;
      dqoe_q   <= dqoe_d;
      rdy_q    <= rdy_d;
      rv_q     <= rv_d;
      perr_q   <= perr_d;
      busy_q   <= busy_d;
      last_q   <= last_d;
      inpage_q <= inpage_d;
      page_q   <= page_d;
      csn_q    <= csn_d;
      oen_q    <= oen_d;
      wen_q    <= wen_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs straight from flip-flops
  // ----------------------------------------------------------------
  assign req_ready  = rdy_q;
  assign rsp_valid  = rv_q;
  assign rsp_rdata  = rdat_q;
  assign page_err   = perr_q;
  assign write_busy = busy_q;
  assign mem_addr   = addr_q;
  assign mem_cs_n   = csn_q;
  assign mem_oe_n   = oen_q;
  assign mem_we_n   = wen_q;
  assign mem_dq_o   = wdat_q;
  assign mem_dq_oe  = dqoe_q;

endmodule

/* src/peb_pkg.sv */
// Package of constants for the parallel nonvolatile memory host controller
package peb_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W      = 16;
  localparam int DATA_W      = 8;
  localparam int PAGE_OFS_W  = 7;   // Byte position within a 128-byte page
  localparam int PAGE_BYTES  = 128;

  // ----------------------------------------------------------------
  // Timing (core_clk at 10 MHz)
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int CLK_MHZ       = 10;
  // Longest internal write time, in ms
  localparam int INTERNAL_WRITE_TIME_MS = 10;
  localparam int WRITE_WAIT_CYC = INTERNAL_WRITE_TIME_MS * 1000 * CLK_MHZ;
  // Least strobe pulse width, in ns (write enable or chip select)
  localparam int STROBE_NS  = 100;
  localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Longest read access time allowed for the slowest grade, in ns
  localparam int ACCESS_NS  = 250;
  localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Output float time after deselect, in ns
  localparam int FLOAT_NS   = 50;
  localparam int FLOAT_CYC  = (FLOAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Longest time between two byte loads of a page, in us
  localparam int BYTE_LOAD_MAX_US = 100;
  localparam int BYTE_LOAD_MAX_CYC = BYTE_LOAD_MAX_US * CLK_MHZ;

  localparam int CNT_W = 24;

  // ----------------------------------------------------------------
  // Host commands
  // ----------------------------------------------------------------
  localparam logic [1:0] CMD_READ  = 2'h0;
  localparam logic [1:0] CMD_WRITE = 2'h1;
  localparam logic [1:0] CMD_POLL  = 2'h2;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [6:0] {
    PEB_IDLE   = 7'h01,
    PEB_RD     = 7'h02,
    PEB_WR     = 7'h04,
    PEB_RECOV  = 7'h08,
    PEB_FLOAT  = 7'h10,
    PEB_BUSY   = 7'h20,
    PEB_LOADGP = 7'h40
  } peb_state_t;

endpackage

/* src/peb_timer.sv */
// Down counter used for strobe, access and internal write waits
module peb_timer
  import peb_pkg::*;
(
  // Clock and control
  input  wire logic                      core_clk,
  input  wire logic                      srst,
  input  wire logic                      ce,
  // Load and status
  input  wire logic                      load,
  input  wire logic [peb_pkg::CNT_W-1:0] load_val,
  output logic                           done
);

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;

  // Next count: load wins, else step toward zero
  always_comb begin
    cnt_d = cnt_q;
    if (load) begin
      cnt_d = load_val;
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - CNT_W'(1);
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      cnt_q <= '0;
    end else if (ce) begin
      cnt_q <= cnt_d;
    end
  end

  assign done = (cnt_q == '0);

endmodule

/* tb/peb_host_chk.sv */
// Checker of the host strobe protocol, bound to the host controller
module peb_chk (
  // Clock and reset
  input wire logic                        core_clk,
  input wire logic                        srst,
  // User status
  input wire logic                        req_ready,
  input wire logic                        rsp_valid,
  input wire logic                        write_busy,
  input wire logic                        page_err,
  // Memory pins
  input wire logic [peb_pkg::ADDR_W-1:0] mem_addr,
  input wire logic                        mem_cs_n,
  input wire logic                        mem_oe_n,
  input wire logic                        mem_we_n,
  input wire logic                        mem_dq_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  import peb_pkg::*;
  // One clock domain, so clocking and reset are given once
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  a_no_dual_strb: assert property (!(!mem_oe_n && !mem_we_n))
    else $error("oe and we low together");
  a_idle_quiet: assert property (req_ready |-> mem_cs_n && mem_we_n && mem_oe_n)
    else $error("strobe active while ready");
  a_we_width: assert property ($fell(mem_we_n) |=> !mem_we_n ##1 mem_we_n)
    else $error("we pulse length wrong");
  a_wr_drives: assert property (!mem_we_n |-> mem_dq_oe && !mem_cs_n)
    else $error("write without data or select");
  a_wr_addr_hold: assert property (!mem_we_n && !$past(mem_we_n) |-> $stable(mem_addr))
    else $error("address moved during write");
  a_rd_floats: assert property (!mem_oe_n |-> !mem_dq_oe)
    else $error("host drives data during read");
  a_rd_length: assert property ($fell(mem_oe_n) |-> ##4 (mem_oe_n && rsp_valid))
    else $error("read cycle length wrong");
  a_busy_no_wr: assert property (write_busy |-> mem_we_n)
    else $error("write during internal write time");
  a_err_sticky: assert property (page_err |=> page_err)
    else $error("page error cleared");
  // Main scenarios reached
  c_read: cover property ($fell(mem_oe_n));
  c_write: cover property ($fell(mem_we_n));
  c_busy: cover property ($rose(write_busy));
  c_err: cover property ($rose(page_err));
endmodule

bind peb_host peb_chk u_chk (.core_clk(core_clk), .srst(srst), .req_ready(req_ready),
  .rsp_valid(rsp_valid), .write_busy(write_busy), .page_err(page_err),
  .mem_addr(mem_addr), .mem_cs_n(mem_cs_n), .mem_oe_n(mem_oe_n),
  .mem_we_n(mem_we_n), .mem_dq_oe(mem_dq_oe));

/* tb/peb_mem_model.sv */
// Behavioural model of the byte-wide self-timed memory
module peb_mem_model #(
  parameter int BUSY_CYC = 30
) (
  // Clock for the model's own timing
  input wire logic                        core_clk,
  // Pins
  input wire logic [peb_pkg::ADDR_W-1:0] addr,
  input wire logic                        cs_n,
  input wire logic                        oe_n,
  input wire logic                        we_n,
  input wire logic                        host_oe,
  input wire logic [peb_pkg::DATA_W-1:0] host_d,
  output logic     [peb_pkg::DATA_W-1:0] dq
);
  timeunit 1ns;
  timeprecision 1ns;
  import peb_pkg::*;
  logic [7:0]  mem [0:65535];
  logic [15:0] wa_q;
  logic [7:0]  wd_q;
  logic [7:0]  bus_q;
  logic        ld_q;
  logic        drv;
  int          cnt_q;
  initial begin
    ld_q = 1'b0;
    cnt_q = 0;
    bus_q = 8'h00;
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 8'(i) ^ 8'(i >> 8);
    end
  end
  // Drives only in read decode; floats when either select rises
  assign drv = !cs_n && !oe_n && we_n;
  // Released bus shows the inverse of its last level, never a stale copy
  assign dq = host_oe ? host_d : !drv ? ~bus_q
              : (cnt_q > 0) ? {~wd_q[7], wd_q[6:0]} : mem[addr];
  // Byte is taken when the write strobe pair ends
  always @(posedge core_clk) begin
    bus_q <= dq;
    if (cnt_q > 0) begin
      cnt_q <= cnt_q - 1;
    end
    if (!cs_n && !we_n) begin
      wa_q <= addr;
      wd_q <= host_d;
      ld_q <= 1'b1;
    end else if (ld_q) begin
      ld_q <= 1'b0;
      mem[wa_q] <= wd_q;
      cnt_q <= BUSY_CYC;
    end
  end
endmodule

/* tb/tb_top.sv */
// Self-checking bench for the host controller and memory model
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import peb_pkg::*;
  logic core_clk, srst, req_valid, req_last, req_ready, rsp_valid, page_err, write_busy;
  logic cs_n, oe_n, we_n, dq_oe;
  logic [1:0] req_cmd;
  logic [15:0] req_addr, addr, pg;
  logic [7:0] req_wdata, rdata, dq_o, dq_i, d;
  logic [7:0] sh [int];
  int bad_count, tests_run, cyc;
  logic [31:0] rs;
  peb_host #(.WRITE_WAIT(50)) dut (.core_clk(core_clk), .srst(srst), .clk_en(1'b1),
    .req_valid(req_valid), .req_cmd(req_cmd), .req_addr(req_addr), .req_wdata(req_wdata),
    .req_last(req_last), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rdata),
    .page_err(page_err), .write_busy(write_busy), .mem_addr(addr), .mem_cs_n(cs_n),
    .mem_oe_n(oe_n), .mem_we_n(we_n), .mem_dq_i(dq_i), .mem_dq_o(dq_o), .mem_dq_oe(dq_oe));
  peb_mem_model #(.BUSY_CYC(30)) u_mem (.core_clk(core_clk), .addr(addr), .cs_n(cs_n),
    .oe_n(oe_n), .we_n(we_n), .host_oe(dq_oe), .host_d(dq_o), .dq(dq_i));
  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  // Unwritten cells hold a pattern made from their address
  function automatic logic [7:0] ev(logic [15:0] a);
    return sh.exists(a) ? sh[a] : a[7:0] ^ a[15:8];
  endfunction
  task automatic summarize();
    if (bad_count == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(string n, logic [15:0] s, logic [15:0] e);
    tests_run++;
    if (s !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  // Waits for ready (or busy, for a poll), presents one request for one edge
  task automatic req(logic [1:0] c, logic [15:0] a, logic [7:0] wd, logic l);
    for (int n = 0; n < 3000; n++) begin
      if (req_ready === 1'b1 || (c == CMD_POLL && write_busy === 1'b1)) break;
      @(negedge core_clk);
    end
    req_valid = 1'b1;
    req_cmd = c;
    req_addr = a;
    req_wdata = wd;
    req_last = l;
    @(negedge core_clk);
    req_valid = 1'b0;
  endtask
  task automatic wr(logic [15:0] a, logic [7:0] wd, logic l);
    req(CMD_WRITE, a, wd, l);
    sh[a] = wd;
  endtask
  task automatic rd(logic [1:0] c, logic [15:0] a, logic [7:0] e);
    req(c, a, 8'h00, 1'b0);
    for (int n = 0; n < 20 && rsp_valid !== 1'b1; n++) begin
      @(posedge core_clk);
      #1;
    end
    chk("rsp_valid", {15'h0, rsp_valid}, 16'h1);
    chk("rsp_rdata", {8'h00, rdata}, {8'h00, e});
  endtask
  task automatic wait_flag(logic v, int lim);
    for (int n = 0; n < lim && write_busy !== v; n++) begin
      @(negedge core_clk);
    end
  endtask
  // Clock and cycle ceiling
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      summarize();
    end
  end
  initial begin
    {bad_count, tests_run, cyc, req_valid, req_last} = '0;
    {req_cmd, req_addr, req_wdata} = '0;
    rs = 32'h0000_76FA;
    srst = 1'b1;
    repeat (6) @(negedge core_clk);
    srst = 1'b0;
    // Random pages: four loads, poll during busy, read back
    repeat (3) begin
      pg = 16'(rnd() & 32'hFF80);
      d = 8'(rnd());
      for (int i = 0; i < 4; i++) begin
        d = 8'(rnd());
        wr(pg | 16'((i * 37 + rs) & 32'h7F), d, i == 3);
      end
      wait_flag(1'b1, 20);
      chk("write_busy", {15'h0, write_busy}, 16'h1);
      rd(CMD_POLL, pg, {~d[7], d[6:0]});
      repeat (40) @(negedge core_clk);
      foreach (sh[k]) rd(CMD_READ, 16'(k), sh[k]);
    end
    // Single load left open: gap expiry starts the write, host waits it out
    wr(16'hFFFF, 8'h5A, 1'b0);
    wait_flag(1'b1, 1100);
    chk("write_busy", {15'h0, write_busy}, 16'h1);
    chk("req_ready", {15'h0, req_ready}, 16'h0);
    wait_flag(1'b0, 100);
    rd(CMD_READ, 16'hFFFF, 8'h5A);
    rd(CMD_READ, 16'h0000, ev(16'h0000));
    // Page bits changed in mid-page, then a second reset
    wr(16'h1280, 8'hA5, 1'b0);
    wr(16'h1300, 8'h3C, 1'b0);
    chk("page_err", {15'h0, page_err}, 16'h1);
    srst = 1'b1;
    repeat (6) @(negedge core_clk);
    srst = 1'b0;
    chk("page_err", {15'h0, page_err}, 16'h0);
    summarize();
  end
endmodule
